// ==== shared/dhec_pkg.sv ====
// shared constants and types for the debug halt event catch block
package dhec_pkg;
  // comparator counts
  localparam int NUM_BP = 6;
  localparam int NUM_WP = 4;
  localparam int ADDR_W = 64;
  localparam int ASID_W = 16;
  localparam int MID_W = 16;

  // exception level encodings on the core status ports
  localparam logic [1:0] LVL0 = 2'h0;
  localparam logic [1:0] LVL1 = 2'h1;
  localparam logic [1:0] LVL2 = 2'h2;
  localparam logic [1:0] LVL3 = 2'h3;

  // security state encodings
  localparam logic [1:0] SEC_NONSECURE = 2'h0;
  localparam logic [1:0] SEC_SECURE = 2'h1;
  localparam logic [1:0] SEC_REALM = 2'h2;

  // catch vector bit positions
  localparam int CAT_RESET = 0;
  localparam int CAT_OS_UNLOCK_CATCH = 1;
  localparam int CAT_NS1_CHG = 2;
  localparam int CAT_NS2_CHG = 3;
  localparam int CAT_S1_CHG = 4;
  localparam int CAT_S3_CHG = 5;
  localparam int CAT_NS1_ENT = 6;
  localparam int CAT_NS2_ENT = 7;
  localparam int CAT_S1_ENT = 8;
  localparam int CAT_S3_ENT = 9;
  localparam int CAT_NS0_RET = 10;
  localparam int CAT_NS1_RET = 11;
  localparam int CAT_NS2_RET = 12;
  localparam int CAT_S0_RET = 13;
  localparam int CAT_S1_RET = 14;
  localparam int CAT_S3_RET = 15;
  localparam int CAT_S2_CHG = 16;
  localparam int CAT_S2_ENT = 17;
  localparam int CAT_S2_RET = 18;
  localparam int CAT_RL0_RET = 19;
  localparam int CAT_RL1_CHG = 20;
  localparam int CAT_RL1_ENT = 21;
  localparam int CAT_RL1_RET = 22;
  localparam int CAT_RL2_CHG = 23;
  localparam int CAT_RL2_ENT = 24;
  localparam int CAT_RL2_RET = 25;
  localparam int CAT_W = 26;

  // catch vector after reset or default command: reset catch only
  localparam logic [CAT_W-1:0] CAT_DEFAULT = 26'h0000001;

  // control defaults: asid off, machine off, zone on, step-into off
  localparam logic ASID_QUAL_DEFAULT = 1'b0;
  localparam logic MACH_QUAL_DEFAULT = 1'b0;
  localparam logic ZONE_QUAL_DEFAULT = 1'b1;
  localparam logic STEP_INTO_DEFAULT = 1'b0;

  // halt cause states
  typedef enum logic [2:0] {
    DHEC_RUN = 3'h1,
    DHEC_HALT = 3'h2,
    DHEC_RESUME = 3'h4
  } dhec_state_t;
endpackage

// ==== verilog/dhec_addr_cmp.sv ====
// one qualified address comparator for breakpoints or watchpoints
module dhec_addr_cmp #(
  parameter int AW = 64,
  parameter int IW = 16,
  parameter int MW = 16
) (
  input wire logic enable,
  input wire logic [AW-1:0] cmpAddr,
  input wire logic [IW-1:0] cmpAsid,
  input wire logic [MW-1:0] cmpMachine,
  input wire logic cmpZone,
  input wire logic [AW-1:0] curAddr,
  input wire logic [IW-1:0] curAsid,
  input wire logic [MW-1:0] curMachine,
  input wire logic curZone,
  input wire logic asidQual,
  input wire logic machQual,
  input wire logic zoneQual,
  output logic hit
);
  always_comb begin
    hit = enable && (cmpAddr == curAddr)
      && (!asidQual || (cmpAsid == curAsid))
      && (!machQual || (cmpMachine == curMachine))
      && (!zoneQual || (cmpZone == curZone));
  end
endmodule

// ==== verilog/debug_halt_event_catch.sv ====
// debug halt event catch: qualified comparators, exception catches, step control
// Behaviour
// - asid qualification on: breakpoint halt needs address and asid match; off: address only
// - machine qualification on with identity extension: breakpoint halt needs address and machine match; default off
// - zone qualification on (default) with zone address spaces on: address and zone must match; otherwise zone is ignored
// - trace trigger fires on every breakpoint and watchpoint hit, also while halted when no halt is requested
// - after defaults only the reset catch is enabled; several may combine
// - enabled reset and os unlock catches halt the core
// - debug register access trap halts on register access and lock clear
// - level change catches halt on change to selected level and state
// - entry catches halt on exception entry from a lower level
// - return catches halt on exception return from a higher level
// - secure level 2 change, entry and return catches when supported
// - realm catches: return to level 0, change/entry/return levels 1 and 2
// - early cores: leaving debug acts as return to current level, may re-halt
// - step-into setting drives halting step enable bit of execution control
module debug_halt_event_catch #(
  parameter int NUM_BP = dhec_pkg::NUM_BP,
  parameter int NUM_WP = dhec_pkg::NUM_WP,
  parameter int AW = dhec_pkg::ADDR_W,
  parameter int IW = dhec_pkg::ASID_W,
  parameter int MW = dhec_pkg::MID_W,
  parameter bit EARLY_REVISION = 1'b0,
  parameter bit HAS_ENTRY_RETURN = 1'b1,
  parameter bit HAS_SECURE_LVL2 = 1'b1,
  parameter bit HAS_REALM = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  // configuration from the debugger
  input wire logic restoreDefaults,
  input wire logic cfgWrite,
  input wire logic asid_qualify_enable,
  input wire logic machine_qualify_enable,
  input wire logic zone_qualify_enable,
  input wire logic zone_address_spaces_enable,
  input wire logic machine_identity_extend,
  input wire logic step_into_handler,
  input wire logic debug_reg_access_trap,
  input wire logic [dhec_pkg::CAT_W-1:0] catchEnable,
  input wire logic [NUM_BP-1:0] instr_comparator_en,
  input wire logic [NUM_BP*AW-1:0] instr_comparator_addr,
  input wire logic [NUM_BP*IW-1:0] instr_comparator_asid,
  input wire logic [NUM_BP*MW-1:0] instr_comparator_machine,
  input wire logic [NUM_BP-1:0] instr_comparator_zone,
  input wire logic [NUM_WP-1:0] data_comparator_en,
  input wire logic [NUM_WP*AW-1:0] data_comparator_addr,
  input wire logic [NUM_WP-1:0] data_comparator_zone,
  input wire logic [NUM_BP-1:0] bpReserve,
  input wire logic [NUM_WP-1:0] wpReserve,
  // core status, same clock
  input wire logic [AW-1:0] instrAddr,
  input wire logic instrValid,
  input wire logic [AW-1:0] dataAddr,
  input wire logic dataValid,
  input wire logic [IW-1:0] curAsid,
  input wire logic [MW-1:0] curMachine,
  input wire logic curZone,
  input wire logic coreResetEvent,
  input wire logic osUnlockEvent,
  input wire logic debugRegAccess,
  input wire logic osLockClear,
  input wire logic excEntry,
  input wire logic excReturn,
  input wire logic [1:0] newLevel,
  input wire logic [1:0] oldLevel,
  input wire logic [1:0] newSecurity,
  input wire logic debugExit,
  input wire logic [1:0] curLevel,
  input wire logic [1:0] curSecurity,
  input wire logic coreHalted,
  // outputs
  output logic haltRequest,
  output logic traceTrigger,
  output logic halting_step_enable,
  output logic resumeRehalt,
  output logic [dhec_pkg::CAT_W-1:0] catchState,
  output logic [NUM_BP-1:0] bpReservedState,
  output logic [NUM_WP-1:0] wpReservedState,
  output logic [2:0] haltState
);
  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  logic asidQual_ff, nxt_asidQual;
  logic machQual_ff, nxt_machQual;
  logic zoneQual_ff, nxt_zoneQual;
  logic stepInto_ff, nxt_stepInto;
  logic trapDra_ff, nxt_trapDra;
  logic [dhec_pkg::CAT_W-1:0] catch_ff, nxt_catch;
  logic [NUM_BP-1:0] bpRes_ff, nxt_bpRes;
  logic [NUM_WP-1:0] wpRes_ff, nxt_wpRes;
  logic [dhec_pkg::CAT_W-1:0] catchSupported;

  // unsupported catch bits stay clear so the debugger can read back capability
  // groups from the top: realm, secure level 2, entry and return, base catches
  assign catchSupported = {{7{HAS_REALM}}, {3{HAS_SECURE_LVL2}}, {10{HAS_ENTRY_RETURN}}, 6'h3F};

  always_comb begin
    nxt_asidQual = asidQual_ff;
    nxt_machQual = machQual_ff;
    nxt_zoneQual = zoneQual_ff;
    nxt_stepInto = stepInto_ff;
    nxt_trapDra = trapDra_ff;
    nxt_catch = catch_ff;
    nxt_bpRes = bpRes_ff;
    nxt_wpRes = wpRes_ff;
    if (restoreDefaults) begin
      nxt_asidQual = dhec_pkg::ASID_QUAL_DEFAULT;
      nxt_machQual = dhec_pkg::MACH_QUAL_DEFAULT;
      nxt_zoneQual = dhec_pkg::ZONE_QUAL_DEFAULT;
      nxt_stepInto = dhec_pkg::STEP_INTO_DEFAULT;
      nxt_trapDra = 1'b0;
      nxt_catch = dhec_pkg::CAT_DEFAULT;
      nxt_bpRes = '0;
      nxt_wpRes = '0;
    end else if (cfgWrite) begin
      nxt_asidQual = asid_qualify_enable;
      // machine match needs the identity extension to be usable
      nxt_machQual = machine_qualify_enable && machine_identity_extend;
      nxt_zoneQual = zone_qualify_enable;
      nxt_stepInto = step_into_handler;
      nxt_trapDra = debug_reg_access_trap;
      nxt_catch = catchEnable & catchSupported;
      nxt_bpRes = bpReserve;
      nxt_wpRes = wpReserve;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      asidQual_ff <= dhec_pkg::ASID_QUAL_DEFAULT;
      machQual_ff <= dhec_pkg::MACH_QUAL_DEFAULT;
      zoneQual_ff <= dhec_pkg::ZONE_QUAL_DEFAULT;
      stepInto_ff <= dhec_pkg::STEP_INTO_DEFAULT;
      trapDra_ff <= 1'b0;
      catch_ff <= dhec_pkg::CAT_DEFAULT;
      bpRes_ff <= '0;
      wpRes_ff <= '0;
    end else begin
      asidQual_ff <= nxt_asidQual;
      machQual_ff <= nxt_machQual;
      zoneQual_ff <= nxt_zoneQual;
      stepInto_ff <= nxt_stepInto;
      trapDra_ff <= nxt_trapDra;
      catch_ff <= nxt_catch;
      bpRes_ff <= nxt_bpRes;
      wpRes_ff <= nxt_wpRes;
    end
  end

  // ------------------------------------------------------------
  // comparators
  // ------------------------------------------------------------
  logic [NUM_BP-1:0] bpHit;
  logic [NUM_WP-1:0] wpHit;
  logic effZoneQual;

  // zone qualification only bites once zone address spaces are on
  assign effZoneQual = zoneQual_ff && zone_address_spaces_enable;

  for (genvar i = 0; i < NUM_BP; i++) begin : gBp
    dhec_addr_cmp #(.AW(AW), .IW(IW), .MW(MW)) uCmp (
      .enable(instr_comparator_en[i] && instrValid),
      .cmpAddr(instr_comparator_addr[i*AW +: AW]),
      .cmpAsid(instr_comparator_asid[i*IW +: IW]),
      .cmpMachine(instr_comparator_machine[i*MW +: MW]),
      .cmpZone(instr_comparator_zone[i]),
      .curAddr(instrAddr),
      .curAsid(curAsid),
      .curMachine(curMachine),
      .curZone(curZone),
      .asidQual(asidQual_ff),
      .machQual(machQual_ff),
      .zoneQual(effZoneQual),
      .hit(bpHit[i])
    );
  end

  // watchpoints compare data address and zone; asid and machine are not carried
  for (genvar j = 0; j < NUM_WP; j++) begin : gWp
    dhec_addr_cmp #(.AW(AW), .IW(IW), .MW(MW)) uCmp (
      .enable(data_comparator_en[j] && dataValid),
      .cmpAddr(data_comparator_addr[j*AW +: AW]),
      .cmpAsid(curAsid),
      .cmpMachine(curMachine),
      .cmpZone(data_comparator_zone[j]),
      .curAddr(dataAddr),
      .curAsid(curAsid),
      .curMachine(curMachine),
      .curZone(curZone),
      .asidQual(1'b0),
      .machQual(1'b0),
      .zoneQual(effZoneQual),
      .hit(wpHit[j])
    );
  end

  // ------------------------------------------------------------
  // exception catch decode
  // ------------------------------------------------------------
  function automatic logic [3:0] lvl_hot(input logic [1:0] lvl, input logic [1:0] sec,
                                         input logic [1:0] wantSec);
    lvl_hot = (sec == wantSec) ? (4'h1 << lvl) : 4'h0;
  endfunction

  logic [dhec_pkg::CAT_W-1:0] catchFire;
  logic levelChange;
  logic [3:0] nsHot, sHot, rlHot, curNsHot, curSHot;

  always_comb begin
    levelChange = (excEntry || excReturn) && (newLevel != oldLevel);
    nsHot = lvl_hot(newLevel, newSecurity, dhec_pkg::SEC_NONSECURE);
    sHot = lvl_hot(newLevel, newSecurity, dhec_pkg::SEC_SECURE);
    rlHot = lvl_hot(newLevel, newSecurity, dhec_pkg::SEC_REALM);
    curNsHot = lvl_hot(curLevel, curSecurity, dhec_pkg::SEC_NONSECURE);
    curSHot = lvl_hot(curLevel, curSecurity, dhec_pkg::SEC_SECURE);
    catchFire = '0;
    catchFire[dhec_pkg::CAT_RESET] = coreResetEvent;
    catchFire[dhec_pkg::CAT_OS_UNLOCK_CATCH] = osUnlockEvent;
    catchFire[dhec_pkg::CAT_NS1_CHG] = levelChange && nsHot[1];
    catchFire[dhec_pkg::CAT_NS2_CHG] = levelChange && nsHot[2];
    catchFire[dhec_pkg::CAT_S1_CHG] = levelChange && sHot[1];
    catchFire[dhec_pkg::CAT_S3_CHG] = levelChange && sHot[3];
    catchFire[dhec_pkg::CAT_NS1_ENT] = excEntry && nsHot[1];
    catchFire[dhec_pkg::CAT_NS2_ENT] = excEntry && nsHot[2];
    catchFire[dhec_pkg::CAT_S1_ENT] = excEntry && sHot[1];
    catchFire[dhec_pkg::CAT_S3_ENT] = excEntry && sHot[3];
    catchFire[dhec_pkg::CAT_NS0_RET] = excReturn && nsHot[0];
    catchFire[dhec_pkg::CAT_NS1_RET] = excReturn && nsHot[1];
    catchFire[dhec_pkg::CAT_NS2_RET] = excReturn && nsHot[2];
    catchFire[dhec_pkg::CAT_S0_RET] = excReturn && sHot[0];
    catchFire[dhec_pkg::CAT_S1_RET] = excReturn && sHot[1];
    catchFire[dhec_pkg::CAT_S3_RET] = excReturn && sHot[3];
    catchFire[dhec_pkg::CAT_S2_CHG] = levelChange && sHot[2];
    catchFire[dhec_pkg::CAT_S2_ENT] = excEntry && sHot[2];
    catchFire[dhec_pkg::CAT_S2_RET] = excReturn && sHot[2];
    catchFire[dhec_pkg::CAT_RL0_RET] = excReturn && rlHot[0];
    catchFire[dhec_pkg::CAT_RL1_CHG] = levelChange && rlHot[1];
    catchFire[dhec_pkg::CAT_RL1_ENT] = excEntry && rlHot[1];
    catchFire[dhec_pkg::CAT_RL1_RET] = excReturn && rlHot[1];
    catchFire[dhec_pkg::CAT_RL2_CHG] = levelChange && rlHot[2];
    catchFire[dhec_pkg::CAT_RL2_ENT] = excEntry && rlHot[2];
    catchFire[dhec_pkg::CAT_RL2_RET] = excReturn && rlHot[2];
    // leaving debug on early cores looks like a return to the current level
    if (EARLY_REVISION && debugExit) begin
      catchFire[dhec_pkg::CAT_NS1_CHG] = curNsHot[1];
      catchFire[dhec_pkg::CAT_NS2_CHG] = curNsHot[2];
      catchFire[dhec_pkg::CAT_S1_CHG] = curSHot[1];
      catchFire[dhec_pkg::CAT_S3_CHG] = curSHot[3];
    end
  end

  logic catchHit, drHit, cmpHit, anyHalt;
  assign catchHit = |(catchFire & catch_ff);
  assign drHit = trapDra_ff && (debugRegAccess || osLockClear);
  assign cmpHit = |bpHit || |wpHit;
  assign anyHalt = catchHit || drHit || cmpHit;

  // ------------------------------------------------------------
  // halt request sequencing
  // ------------------------------------------------------------
  dhec_pkg::dhec_state_t state_ff, nxt_state;
  logic halt_ff, nxt_halt;
  logic trace_ff, nxt_trace;
  logic rehalt_ff, nxt_rehalt;

  always_comb begin
    nxt_state = state_ff;
    nxt_halt = 1'b0;
    nxt_trace = cmpHit;
    nxt_rehalt = rehalt_ff;
    case (state_ff)
      dhec_pkg::DHEC_RUN: begin
        if (anyHalt && !coreHalted) begin
          nxt_halt = 1'b1;
          nxt_state = dhec_pkg::DHEC_HALT;
          nxt_rehalt = 1'b0;
        end
      end
      dhec_pkg::DHEC_HALT: begin
        // hold request until the core reports halted, then wait for exit
        // once dropped, stays low unless a catch hits on exit: coreHalted falls again on exit
        nxt_halt = halt_ff && !coreHalted;
        if (debugExit) begin
          nxt_state = dhec_pkg::DHEC_RESUME;
          if (catchHit) begin
            // caught before any instruction ran: flag for the debugger warning
            nxt_rehalt = 1'b1;
            nxt_halt = 1'b1;
            nxt_state = dhec_pkg::DHEC_HALT;
          end
        end
      end
      dhec_pkg::DHEC_RESUME: begin
        nxt_state = dhec_pkg::DHEC_RUN;
        if (anyHalt) begin
          nxt_halt = 1'b1;
          nxt_state = dhec_pkg::DHEC_HALT;
        end
      end
      default: begin
        nxt_state = dhec_pkg::DHEC_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_ff <= dhec_pkg::DHEC_RUN;
      halt_ff <= 1'b0;
      trace_ff <= 1'b0;
      rehalt_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      halt_ff <= nxt_halt;
      trace_ff <= nxt_trace;
      rehalt_ff <= nxt_rehalt;
    end
  end

  assign haltRequest = halt_ff;
  assign traceTrigger = trace_ff;
  assign halting_step_enable = stepInto_ff;
  assign resumeRehalt = rehalt_ff;
  assign catchState = catch_ff;
  assign bpReservedState = bpRes_ff;
  assign wpReservedState = wpRes_ff;
  assign haltState = state_ff;
endmodule

// ==== dv/dhec_halt_monitor.sv ====
// concurrent checks on the ports of the debug halt event catch block
module dhec_halt_monitor #(
  parameter int NUM_BP = 6,
  parameter bit EARLY_REVISION = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic restoreDefaults,
  input wire logic cfgWrite,
  input wire logic step_into_handler,
  input wire logic [dhec_pkg::CAT_W-1:0] catchEnable,
  input wire logic coreResetEvent,
  input wire logic osUnlockEvent,
  input wire logic instrValid,
  input wire logic dataValid,
  input wire logic coreHalted,
  input wire logic haltRequest,
  input wire logic traceTrigger,
  input wire logic halting_step_enable,
  input wire logic resumeRehalt,
  input wire logic [dhec_pkg::CAT_W-1:0] catchState,
  input wire logic [NUM_BP-1:0] bpReservedState,
  input wire logic [2:0] haltState
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // properties
  // ----------------------------------------
  a_reset_catch_only: assert property (
    !$past(rst_n) |-> catchState == dhec_pkg::CAT_DEFAULT && haltState == 3'h1)
    else $error("catch state or run state wrong after reset");
  a_default_cmd: assert property (
    restoreDefaults |=> catchState == dhec_pkg::CAT_DEFAULT && !halting_step_enable
      && bpReservedState == '0)
    else $error("default command did not restore settings");
  a_catch_loaded: assert property (
    cfgWrite && !restoreDefaults |=> catchState == $past(catchEnable))
    else $error("catch enables not stored");
  a_step_follows: assert property (
    cfgWrite && !restoreDefaults |=> halting_step_enable == $past(step_into_handler))
    else $error("halting step enable does not follow step setting");
  a_reset_halt: assert property (
    coreResetEvent && catchState[dhec_pkg::CAT_RESET] && haltState == 3'h1 && !coreHalted
      |=> haltRequest)
    else $error("reset catch did not halt");
  a_unlock_halt: assert property (
    osUnlockEvent && catchState[dhec_pkg::CAT_OS_UNLOCK_CATCH] && haltState == 3'h1 && !coreHalted
      |=> haltRequest)
    else $error("unlock catch did not halt");
  a_halt_holds: assert property (haltRequest && !coreHalted |=> haltRequest)
    else $error("halt request dropped before the core halted");
  a_halt_release: assert property (haltRequest && coreHalted |=> !haltRequest)
    else $error("halt request kept after the core halted");
  a_trace_cause: assert property (
    traceTrigger |-> $past(instrValid) || $past(dataValid))
    else $error("trace trigger without a comparator access");
  a_no_rehalt: assert property (EARLY_REVISION || !resumeRehalt)
    else $error("re-halt on resume flagged on a later revision");
endmodule

// ==== dv/dhec_core_model.sv ====
// core-side halt handshake model facing the debug halt event catch block
module dhec_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic haltRequest,
  input wire logic resumeCmd,
  input wire logic [3:0] latency,
  output logic coreHalted,
  output logic debugExit
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] waitCnt;
  always @(posedge clk) begin
    debugExit <= 1'b0;
    if (!rst_n) begin
      coreHalted <= 1'b0;
      waitCnt <= 4'h0;
    end else if (coreHalted) begin
      waitCnt <= 4'h0;
      if (resumeCmd) begin
        // leaving debug looks like a return to the current level
        coreHalted <= 1'b0;
        debugExit <= 1'b1;
      end
    end else if (haltRequest) begin
      // slow core: request must stand for latency extra cycles
      if (waitCnt >= latency) coreHalted <= 1'b1;
      waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

// ==== dv/test_debug_halt_event_catch.sv ====
// self-checking bench for the debug halt event catch block
module test_debug_halt_event_catch;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int AW = dhec_pkg::ADDR_W;
  logic clk, rst_n, restoreDefaults, cfgWrite, asid_qualify_enable, machine_qualify_enable;
  logic zone_qualify_enable, zone_address_spaces_enable, machine_identity_extend, resumeCmd;
  logic step_into_handler, debug_reg_access_trap, instrValid, dataValid, curZone;
  logic coreResetEvent, osUnlockEvent, debugRegAccess, osLockClear, excEntry, excReturn;
  logic coreHalted, debugExit, haltRequest, traceTrigger, halting_step_enable, resumeRehalt;
  logic [1:0] newLevel, oldLevel, newSecurity, curLevel, curSecurity;
  logic [2:0] haltState;
  logic [3:0] latency;
  logic [dhec_pkg::CAT_W-1:0] catchEnable, catchState;
  logic [5:0] instr_comparator_en, instr_comparator_zone, bpReserve, bpReservedState;
  logic [3:0] data_comparator_en, data_comparator_zone, wpReserve, wpReservedState;
  logic [6*AW-1:0] instr_comparator_addr;
  logic [95:0] instr_comparator_asid, instr_comparator_machine;
  logic [4*AW-1:0] data_comparator_addr;
  logic [AW-1:0] instrAddr, dataAddr;
  logic [15:0] curAsid, curMachine;
  int n_mismatch, check_count;
  // event code per catch bit: kind, security, level
  logic [7:0] evTab [26] = '{8'h00, 8'h10, 8'h21, 8'h22, 8'h25, 8'h27, 8'h31, 8'h32, 8'h35,
    8'h37, 8'h40, 8'h41, 8'h42, 8'h44, 8'h45, 8'h47, 8'h26, 8'h36, 8'h46, 8'h48, 8'h29,
    8'h39, 8'h49, 8'h2A, 8'h3A, 8'h4A};

  debug_halt_event_catch DUT (.clk, .rst_n, .restoreDefaults, .cfgWrite, .asid_qualify_enable,
    .machine_qualify_enable, .zone_qualify_enable, .zone_address_spaces_enable,
    .machine_identity_extend, .step_into_handler, .debug_reg_access_trap, .catchEnable,
    .instr_comparator_en, .instr_comparator_addr, .instr_comparator_asid,
    .instr_comparator_machine, .instr_comparator_zone, .data_comparator_en,
    .data_comparator_addr, .data_comparator_zone, .bpReserve, .wpReserve, .instrAddr,
    .instrValid, .dataAddr, .dataValid, .curAsid, .curMachine, .curZone, .coreResetEvent,
    .osUnlockEvent, .debugRegAccess, .osLockClear, .excEntry, .excReturn, .newLevel, .oldLevel,
    .newSecurity, .debugExit, .curLevel, .curSecurity, .coreHalted, .haltRequest,
    .traceTrigger, .halting_step_enable, .resumeRehalt, .catchState, .bpReservedState,
    .wpReservedState, .haltState);
  dhec_core_model core (.clk, .rst_n, .haltRequest, .resumeCmd, .latency, .coreHalted,
    .debugExit);

  always #5 clk = ~clk;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic write_cfg();
    cfgWrite = 1'b1;
    @(negedge clk);
    cfgWrite = 1'b0;
    @(negedge clk);
  endtask

  task automatic fire(input logic [7:0] c);
    newLevel = c[1:0];
    newSecurity = c[3:2];
    oldLevel = c[7:4] == 4'h4 ? (c[1:0] == 2'h3 ? 2'h3 : c[1:0] + 2'h1) : c[1:0] - 2'h1;
    coreResetEvent = c[7:4] == 4'h0;
    osUnlockEvent = c[7:4] == 4'h1;
    excEntry = c[7:4] == 4'h2 || c[7:4] == 4'h3;
    excReturn = c[7:4] == 4'h4;
    debugRegAccess = c[7:4] == 4'h5;
    osLockClear = c[7:4] == 4'h6;
    @(negedge clk);
    {coreResetEvent, osUnlockEvent, excEntry, excReturn, debugRegAccess, osLockClear} = 6'h00;
  endtask

  task automatic expect_halt(input string what, input logic exp);
    int i;
    chk(what, 32'(exp), 32'(haltRequest));
    if (exp === 1'b1) begin
      chk("halt state", 32'h2, 32'(haltState));
      for (i = 0; i < 20 && haltRequest !== 1'b0; i++) @(negedge clk);
      chk("request released", 32'h0, 32'(haltRequest));
      resumeCmd = 1'b1;
      @(negedge clk);
      resumeCmd = 1'b0;
      repeat (3) @(negedge clk);
      chk("back to run", 32'h1, 32'({resumeRehalt, haltState}));
    end
  endtask

  task automatic hit(input logic isData, input logic exp);
    instrValid = !isData;
    dataValid = isData;
    @(negedge clk);
    {instrValid, dataValid} = 2'h0;
    chk("trace trigger", 32'(exp), 32'(traceTrigger));
    expect_halt("comparator halt", exp);
  endtask

  task automatic qual(input logic a, input logic m, input logic z, input logic sp);
    {asid_qualify_enable, machine_qualify_enable, zone_qualify_enable} = {a, m, z};
    zone_address_spaces_enable = sp;
    machine_identity_extend = m;
    write_cfg();
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk("catch after reset", 32'(dhec_pkg::CAT_DEFAULT), 32'(catchState));
    chk("step after reset", 32'h0, 32'(halting_step_enable));
    chk("reserved after reset", 32'h0, 32'({bpReservedState, wpReservedState}));
  endtask

  task automatic t_config();
    step_into_handler = 1'b1;
    bpReserve = 6'h3E;
    wpReserve = 4'hC;
    catchEnable = 26'h3FFFFFF;
    write_cfg();
    chk("all catches", 32'h03FFFFFF, 32'(catchState));
    chk("step into", 32'h1, 32'(halting_step_enable));
    chk("reserved", 32'h3EC, 32'({bpReservedState, wpReservedState}));
    {restoreDefaults, cfgWrite} = 2'h3;
    @(negedge clk);
    {restoreDefaults, cfgWrite} = 2'h0;
    @(negedge clk);
    chk("catch defaults", 32'(dhec_pkg::CAT_DEFAULT), 32'(catchState));
    chk("step defaults", 32'h0, 32'(halting_step_enable));
    {bpReserve, wpReserve, step_into_handler} = 11'h000;
  endtask

  task automatic t_catch_table();
    int i;
    for (i = 0; i < dhec_pkg::CAT_W; i++) begin
      latency = i[0] ? 4'h6 : 4'h0;
      catchEnable = '0;
      write_cfg();
      fire(evTab[i]);
      expect_halt("catch off", 1'b0);
      catchEnable = 26'h1 << i;
      write_cfg();
      fire(evTab[i]);
      expect_halt("catch on", 1'b1);
    end
  endtask

  task automatic t_trap();
    int k;
    for (k = 5; k < 7; k++) begin
      debug_reg_access_trap = 1'b0;
      write_cfg();
      fire({k[3:0], 4'h0});
      expect_halt("trap off", 1'b0);
      debug_reg_access_trap = 1'b1;
      write_cfg();
      fire({k[3:0], 4'h0});
      expect_halt("trap on", 1'b1);
    end
    debug_reg_access_trap = 1'b0;
  endtask

  task automatic t_compare();
    catchEnable = '0;
    {instr_comparator_en, instr_comparator_zone, instrAddr} = {6'h01, 6'h01, 64'h100};
    instr_comparator_addr[AW-1:0] = 64'h100;
    {instr_comparator_asid[15:0], instr_comparator_machine[15:0]} = {16'h0005, 16'h0009};
    {curAsid, curMachine, curZone} = {16'h0005, 16'h0009, 1'b0};
    qual(1'b0, 1'b0, 1'b1, 1'b1);
    hit(1'b0, 1'b0);
    curZone = 1'b1;
    hit(1'b0, 1'b1);
    curZone = 1'b0;
    qual(1'b0, 1'b0, 1'b1, 1'b0);
    hit(1'b0, 1'b1);
    qual(1'b1, 1'b0, 1'b0, 1'b1);
    curAsid = 16'h0006;
    hit(1'b0, 1'b0);
    curAsid = 16'h0005;
    hit(1'b0, 1'b1);
    qual(1'b0, 1'b1, 1'b0, 1'b1);
    curMachine = 16'h0008;
    hit(1'b0, 1'b0);
    curMachine = 16'h0009;
    hit(1'b0, 1'b1);
    instr_comparator_en = 6'h00;
    {data_comparator_en, data_comparator_addr[AW-1:0], dataAddr} = {4'h1, 64'h200, 64'h200};
    hit(1'b1, 1'b1);
  endtask

  initial begin
    {clk, rst_n, restoreDefaults, cfgWrite, asid_qualify_enable, machine_qualify_enable} = '0;
    {zone_qualify_enable, zone_address_spaces_enable, machine_identity_extend, resumeCmd} = '0;
    {step_into_handler, debug_reg_access_trap, instrValid, dataValid, curZone} = '0;
    {coreResetEvent, osUnlockEvent, debugRegAccess, osLockClear, excEntry, excReturn} = '0;
    {newLevel, oldLevel, newSecurity, curLevel, curSecurity, latency, catchEnable} = '0;
    {instr_comparator_en, instr_comparator_zone, bpReserve, data_comparator_en} = '0;
    {data_comparator_zone, wpReserve, instr_comparator_addr, data_comparator_addr} = '0;
    {instr_comparator_asid, instr_comparator_machine, instrAddr, dataAddr} = '0;
    {curAsid, curMachine, n_mismatch, check_count} = '0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    @(negedge clk);
    t_reset();
    t_config();
    t_catch_table();
    t_trap();
    t_compare();
    stop_test();
  end

  initial begin
    #200000;
    n_mismatch++;
    stop_test();
  end
endmodule

bind debug_halt_event_catch dhec_halt_monitor #(.NUM_BP(NUM_BP),
  .EARLY_REVISION(EARLY_REVISION)) u_mon (.clk, .rst_n, .restoreDefaults, .cfgWrite,
  .step_into_handler, .catchEnable, .coreResetEvent, .osUnlockEvent, .instrValid, .dataValid,
  .coreHalted, .haltRequest, .traceTrigger, .halting_step_enable, .resumeRehalt, .catchState,
  .bpReservedState, .haltState);
